// file: fsq_addr_step.sv
// Purpose: next read address, linear or folded inside a wrap section
// Assumes: wrap sections are 8, 16, 32 or 64 bytes inside a 256-byte page
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "fsq_regs.svh"
module fsq_addr_step #(
    parameter int AW = 24
) (
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_wrap_en,
    input  wire logic [1:0]    i_len_sel,
    output var  logic [AW-1:0] o_next
);
    if (AW < 9) begin : g_chk
        $error("fsq_addr_step needs an address above one page");
    end

    logic [7:0] mask;
    logic [7:0] low;

    always_comb begin
        mask = (`FSQ_WRAP_MIN << i_len_sel) - 8'h01;
        low  = (i_addr[7:0] & ~mask) | ((i_addr[7:0] + 8'h01) & mask);
        o_next = i_wrap_en ? {i_addr[AW-1:8], low} : i_addr + AW'(1);
    end
endmodule
`default_nettype wire

// file: fsq_host_model.sv
// Purpose: host flash controller driving chip select, serial clock and IO pins
// Assumes: serial clock period 125 ns, mode 0 (clock low while idle)
// Notes:   clock stands still outside frames; released IO lines show the inverse level
`timescale 1ns/10ps
`default_nettype none
module fsq_host_model (
    output var  logic       o_cs_n,
    output var  logic       o_sclk,
    output var  logic [3:0] o_io,
    input  wire logic [3:0] i_io,
    input  wire logic [3:0] i_io_oe
);
    localparam realtime HALF = 62.5;
    logic [7:0] rx [$];
    logic       oe_seen;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_io = 4'hF;
        oe_seen = 1'b0;
    end
    task automatic frame_start();
        rx.delete();
        oe_seen = 1'b0;
        o_cs_n = 1'b0;
        #(HALF);
    endtask
    task automatic frame_end();
        #(HALF);
        o_cs_n = 1'b1;
        o_io = ~o_io;
        #300;
    endtask
    // MSB first, lanes bits per clock; rel frees IO half way through the high phase of the last clock
    task automatic send(input int lanes, input logic [31:0] v, input int nb, input bit rel);
        int i;
        for (i = nb - lanes; i >= 0; i -= lanes) begin
            case (lanes)
                1: o_io = {3'h7, v[i]};
                2: o_io = {2'h3, v[i+:2]};
                default: o_io = v[i+:4];
            endcase
            #(HALF);
            o_sclk = 1'b1;
            #(HALF / 2);
            if (rel && i == 0) o_io = ~o_io;
            #(HALF / 2);
            o_sclk = 1'b0;
        end
    endtask
    task automatic recv(input int lanes, input int nbytes);
        logic [7:0] b;
        logic [3:0] p;
        int i;
        int k;
        for (i = 0; i < nbytes; i++) begin
            for (k = 8 - lanes; k >= 0; k -= lanes) begin
                #(HALF);
                o_sclk = 1'b1;
                oe_seen = oe_seen | (|i_io_oe);
                // Undriven lanes read back inverted, so a missing enable shows
                p = i_io ^ ~i_io_oe;
                case (lanes)
                    1: b[k] = p[1];
                    2: b[k+:2] = p[1:0];
                    default: b[k+:4] = p;
                endcase
                #(HALF);
                o_sclk = 1'b0;
            end
            rx.push_back(b);
        end
    endtask
endmodule
`default_nettype wire

// file: fsq_pin_if.sv
// Purpose: filtered pin levels and edges between synchroniser and sequencer
// Assumes: one system clock
// Notes:   edges are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface fsq_pin_if;
    logic       cs_n;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [3:0] io;
    modport drv (output cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, io);
    modport use_p (input cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, io);
endinterface
`default_nettype wire

// file: fsq_pin_sync.sv
// Purpose: three-stage synchroniser and edge finder for the flash pins
// Assumes: pins asynchronous to i_clk_sys
// Notes:   a level counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
`include "fsq_regs.svh"
module fsq_pin_sync #(
    parameter int W = 6
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    input  wire logic       i_cs_n,
    input  wire logic       i_sclk,
    input  wire logic [3:0] i_io,
    fsq_pin_if.drv          pins
);
    if (W != 6) begin : g_chk
        $error("fsq_pin_sync serves exactly six pins");
    end

    logic [W-1:0] s1_r, s2_r, s3_r, f_r, f_nxt;
    logic         sr_r, sr_nxt, sf_r, sf_nxt, cf_r, cf_nxt, cr_r, cr_nxt;

    always_comb begin
        for (int b = 0; b < W; b++) begin
            f_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : f_r[b];
        end
        sr_nxt = f_nxt[4] & ~f_r[4];
        sf_nxt = ~f_nxt[4] & f_r[4];
        cf_nxt = ~f_nxt[5] & f_r[5];
        cr_nxt = f_nxt[5] & ~f_r[5];
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s1_r <= `FSQ_PIN_RST;
            s2_r <= `FSQ_PIN_RST;
            s3_r <= `FSQ_PIN_RST;
            f_r  <= `FSQ_PIN_RST;
            sr_r <= 1'b0;
            sf_r <= 1'b0;
            cf_r <= 1'b0;
            cr_r <= 1'b0;
        end else begin
            s1_r <= {i_cs_n, i_sclk, i_io};
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r  <= f_nxt;
            sr_r <= sr_nxt;
            sf_r <= sf_nxt;
            cf_r <= cf_nxt;
            cr_r <= cr_nxt;
        end
    end

    assign pins.cs_n      = f_r[5];
    assign pins.io        = f_r[3:0];
    assign pins.sclk_rise = sr_r;
    assign pins.sclk_fall = sf_r;
    assign pins.cs_fall   = cf_r;
    assign pins.cs_rise   = cr_r;
endmodule
`default_nettype wire

// file: fsq_pkg.sv
// Purpose: shared types of the sequencer
// Assumes: nothing
// Notes:   states coded in binary
package fsq_pkg;
    typedef enum logic [2:0] {
        FSQ_ST_CMD    = 3'h0,
        FSQ_ST_ADDR   = 3'h1,
        FSQ_ST_MODE   = 3'h2,
        FSQ_ST_DUMMY  = 3'h3,
        FSQ_ST_DATA   = 3'h4,
        FSQ_ST_WARG   = 3'h5,
        FSQ_ST_IGNORE = 3'h6
    } fsq_state_t;
endpackage

// file: fsq_regs.svh
// Purpose: named constants of the quad read / wrap / id sequencer
// Assumes: included by bare name
// Notes:   counts are serial clocks or bits as named
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH
`define FSQ_OP_WORD_RD   8'hE7
`define FSQ_OP_OCT_RD    8'hE3
`define FSQ_OP_QIO_RD    8'hEB
`define FSQ_OP_SET_WRAP  8'h77
`define FSQ_OP_WRAP_RD   8'h0C
`define FSQ_OP_ID_SGL    8'h90
`define FSQ_OP_ID_DUAL   8'h92
`define FSQ_OP_ID_QUAD   8'h94
`define FSQ_OP_MODE_RST  8'hFF
`define FSQ_CONT_KEEP    2'h2
`define FSQ_MODE_FLD     5:4
`define FSQ_WRAP_DIS_BIT 4
`define FSQ_WRAP_LEN_FLD 6:5
`define FSQ_WRAP_DIS_RST 1'b1
`define FSQ_WRAP_MIN     8'h08
`define FSQ_CMD_BITS     5'h08
`define FSQ_ADDR_BITS    5'h18
`define FSQ_MODE_BITS    5'h08
`define FSQ_WARG_BITS    5'h08
`define FSQ_DUM_WORD     5'h02
`define FSQ_DUM_QIO      5'h04
`define FSQ_DUM_IDQ      5'h04
`define FSQ_DUM_PRM_MIN  5'h02
`define FSQ_BYTE_LAST    3'h7
`define FSQ_OE_X1        4'h2
`define FSQ_OE_X2        4'h3
`define FSQ_OE_X4        4'hF
`define FSQ_PIN_RST      6'h20
`endif

// file: fsq_seq.sv
// Purpose: instruction decode and read sequencing of a serial NOR flash
// Assumes: pins sampled by i_clk_sys, serial clock well below a tenth of it
// Notes:   memory array and id values sit outside, read by o_mem_addr
// What this block does
// - Word read waits two dummy clocks
// - Address advances one per output byte
// - Word read needs the quad enable bit
// - Mode bits 10 keep next transfer opcode-less
// - Other mode bits require an opcode again
// - Mode reset command clears continuous mode bits
// - Wrap folds reads inside the aligned section
// - Wrap disable bit high means off, reset high
// - Wrap length field selects 8 to 64
// - Wrap setting applies until disabled again
// - Octal word read has no dummy clocks
// - Octal read needs the quad enable bit
// - Only mode bits 5:4 matter
// - Continuous octal read starts with address
// - Burst wrap read folds like fast read
// - Burst wrap length and dummies from parameters
// - Id read at zero gives maker then device
// - Id read at one gives device first
// - Dual id two bits, quad four plus dummies
// - Sample on rising edges, drive on falling
`timescale 1ns/10ps
`default_nettype none
`include "fsq_regs.svh"
module fsq_seq (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic [3:0]  i_io,
    output var  logic [3:0]  o_io,
    output var  logic [3:0]  o_io_oe,
    input  wire logic        i_quad_enable,
    input  wire logic        i_four_wire_mode,
    input  wire logic [1:0]  i_param_dummy_sel,
    input  wire logic [1:0]  i_param_wrap_sel,
    input  wire logic [7:0]  i_mfr_id,
    input  wire logic [7:0]  i_dev_id,
    input  wire logic [7:0]  i_mem_data,
    output var  logic [23:0] o_mem_addr,
    output var  logic        o_cont_mode,
    output var  logic        o_wrap_disable,
    output var  logic [1:0]  o_wrap_len
);
    fsq_pin_if pins ();

    fsq_pin_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_cs_n    (i_cs_n),
        .i_sclk    (i_sclk),
        .i_io      (i_io),
        .pins      (pins.drv)
    );

    fsq_pkg::fsq_state_t st_r, st_nxt;
    logic [7:0]  cmd_r, cmd_nxt, cont_cmd_r, cont_cmd_nxt;
    logic [4:0]  cnt_r, cnt_nxt, dum_r, dum_nxt;
    logic [23:0] sh_r, sh_nxt, sh_in, addr_r, addr_nxt, addr_step;
    logic        cont_r, cont_nxt, wdis_r, wdis_nxt, idsel_r, idsel_nxt;
    logic [1:0]  wlen_r, wlen_nxt, wlen_eff, lg, dlg;
    logic [7:0]  dat_r, dat_nxt, byte_v;
    logic [2:0]  bcnt_r, bcnt_nxt;
    logic [3:0]  out_r, out_nxt, oe_r, oe_nxt, oe_lanes;
    logic [4:0]  plen, dumlen, qdum;
    logic        last, is_id, wrap_on;

    function automatic logic [3:0] f_put(input logic [7:0] b, input logic [1:0] l);
        case (l)
            2'h0:    f_put = {2'h0, b[7], 1'b0};
            2'h1:    f_put = {2'h0, b[7:6]};
            default: f_put = b[7:4];
        endcase
    endfunction

    // Lane count per phase as a shift amount: 0 single, 1 dual, 2 quad
    always_comb begin
        case (cmd_r)
            `FSQ_OP_WORD_RD, `FSQ_OP_OCT_RD, `FSQ_OP_QIO_RD,
            `FSQ_OP_ID_QUAD, `FSQ_OP_WRAP_RD: dlg = 2'h2;
            `FSQ_OP_ID_DUAL:                  dlg = 2'h1;
            default:                          dlg = 2'h0;
        endcase
        lg = (st_r == fsq_pkg::FSQ_ST_CMD) ? (i_four_wire_mode ? 2'h2 : 2'h0) : dlg;
        oe_lanes = (dlg == 2'h2) ? `FSQ_OE_X4 : (dlg == 2'h1) ? `FSQ_OE_X2 : `FSQ_OE_X1;
        qdum = {2'h0, i_param_dummy_sel, 1'b0} + `FSQ_DUM_PRM_MIN;
        case (cmd_r)
            `FSQ_OP_WORD_RD: dumlen = `FSQ_DUM_WORD;
            `FSQ_OP_QIO_RD:  dumlen = `FSQ_DUM_QIO;
            `FSQ_OP_ID_QUAD: dumlen = `FSQ_DUM_IDQ;
            `FSQ_OP_WRAP_RD: dumlen = qdum;
            default:         dumlen = 5'h00;
        endcase
        unique case (st_r)
            fsq_pkg::FSQ_ST_CMD:   plen = `FSQ_CMD_BITS >> lg;
            fsq_pkg::FSQ_ST_ADDR:  plen = `FSQ_ADDR_BITS >> lg;
            fsq_pkg::FSQ_ST_MODE:  plen = `FSQ_MODE_BITS >> lg;
            fsq_pkg::FSQ_ST_DUMMY: plen = dumlen;
            fsq_pkg::FSQ_ST_WARG:  plen = `FSQ_WARG_BITS;
            fsq_pkg::FSQ_ST_DATA,
            fsq_pkg::FSQ_ST_IGNORE: plen = 5'h00;
        endcase
        last = (cnt_r + 5'h01) == plen;
        case (lg)
            2'h0:    sh_in = {sh_r[22:0], pins.io[0]};
            2'h1:    sh_in = {sh_r[21:0], pins.io[1:0]};
            default: sh_in = {sh_r[19:0], pins.io};
        endcase
        is_id = (cmd_r == `FSQ_OP_ID_SGL) || (cmd_r == `FSQ_OP_ID_DUAL)
             || (cmd_r == `FSQ_OP_ID_QUAD);
        wrap_on = (cmd_r == `FSQ_OP_WRAP_RD)
               || (((cmd_r == `FSQ_OP_WORD_RD) || (cmd_r == `FSQ_OP_QIO_RD))
                   && !wdis_r);
        wlen_eff = (cmd_r == `FSQ_OP_WRAP_RD) ? i_param_wrap_sel : wlen_r;
        byte_v = is_id ? (idsel_r ? i_dev_id : i_mfr_id) : i_mem_data;
    end

    fsq_addr_step #(
        .AW (24)
    ) u_step (
        .i_addr    (addr_r),
        .i_wrap_en (wrap_on),
        .i_len_sel (wlen_eff),
        .o_next    (addr_step)
    );

    always_comb begin
        st_nxt       = st_r;
        cmd_nxt      = cmd_r;
        cont_cmd_nxt = cont_cmd_r;
        cnt_nxt      = cnt_r;
        dum_nxt      = dum_r;
        sh_nxt       = sh_r;
        addr_nxt     = addr_r;
        cont_nxt     = cont_r;
        wdis_nxt     = wdis_r;
        wlen_nxt     = wlen_r;
        idsel_nxt    = idsel_r;
        dat_nxt      = dat_r;
        bcnt_nxt     = bcnt_r;
        out_nxt      = out_r;
        oe_nxt       = oe_r;
        if (pins.cs_rise) begin
            st_nxt = fsq_pkg::FSQ_ST_IGNORE;
            oe_nxt = 4'h0;
            cnt_nxt = 5'h00;
        end else if (pins.cs_fall) begin
            cnt_nxt = 5'h00;
            dum_nxt = 5'h00;
            bcnt_nxt = 3'h0;
            if (cont_r) begin
                st_nxt = fsq_pkg::FSQ_ST_ADDR;
                cmd_nxt = cont_cmd_r;
            end else begin
                st_nxt = fsq_pkg::FSQ_ST_CMD;
            end
        end else if (pins.sclk_rise && (st_r != fsq_pkg::FSQ_ST_DATA)
                     && (st_r != fsq_pkg::FSQ_ST_IGNORE)) begin
            sh_nxt = sh_in;
            cnt_nxt = cnt_r + 5'h01;
            if (st_r == fsq_pkg::FSQ_ST_DUMMY) begin
                dum_nxt = dum_r + 5'h01;
            end
            if (last) begin
                cnt_nxt = 5'h00;
                unique case (st_r)
                    fsq_pkg::FSQ_ST_CMD: begin
                        cmd_nxt = sh_in[7:0];
                        case (sh_in[7:0])
                            `FSQ_OP_WORD_RD, `FSQ_OP_OCT_RD, `FSQ_OP_QIO_RD,
                            `FSQ_OP_ID_QUAD: st_nxt = i_quad_enable ? fsq_pkg::FSQ_ST_ADDR
                                                   : fsq_pkg::FSQ_ST_IGNORE;
                            `FSQ_OP_ID_SGL, `FSQ_OP_ID_DUAL,
                            `FSQ_OP_SET_WRAP: st_nxt = fsq_pkg::FSQ_ST_ADDR;
                            `FSQ_OP_WRAP_RD: st_nxt = i_four_wire_mode ? fsq_pkg::FSQ_ST_ADDR
                                                   : fsq_pkg::FSQ_ST_IGNORE;
                            `FSQ_OP_MODE_RST: begin
                                cont_nxt = 1'b0;
                                st_nxt = fsq_pkg::FSQ_ST_IGNORE;
                            end
                            default: st_nxt = fsq_pkg::FSQ_ST_IGNORE;
                        endcase
                    end
                    fsq_pkg::FSQ_ST_ADDR: begin
                        addr_nxt = sh_in;
                        idsel_nxt = sh_in[0];
                        case (cmd_r)
                            `FSQ_OP_WORD_RD, `FSQ_OP_OCT_RD,
                            `FSQ_OP_QIO_RD: st_nxt = fsq_pkg::FSQ_ST_MODE;
                            `FSQ_OP_SET_WRAP: st_nxt = fsq_pkg::FSQ_ST_WARG;
                            `FSQ_OP_ID_QUAD,
                            `FSQ_OP_WRAP_RD: st_nxt = fsq_pkg::FSQ_ST_DUMMY;
                            `FSQ_OP_ID_SGL,
                            `FSQ_OP_ID_DUAL: st_nxt = fsq_pkg::FSQ_ST_DATA;
                            default: st_nxt = fsq_pkg::FSQ_ST_IGNORE;
                        endcase
                    end
                    fsq_pkg::FSQ_ST_MODE: begin
                        // Only bits 5:4 decide; low nibble is ignored
                        cont_nxt = sh_in[`FSQ_MODE_FLD] == `FSQ_CONT_KEEP;
                        cont_cmd_nxt = cmd_r;
                        st_nxt = (dumlen == 5'h00) ? fsq_pkg::FSQ_ST_DATA
                                                   : fsq_pkg::FSQ_ST_DUMMY;
                    end
                    fsq_pkg::FSQ_ST_DUMMY: st_nxt = fsq_pkg::FSQ_ST_DATA;
                    fsq_pkg::FSQ_ST_WARG: begin
                        wdis_nxt = sh_in[`FSQ_WRAP_DIS_BIT];
                        wlen_nxt = sh_in[`FSQ_WRAP_LEN_FLD];
                        st_nxt = fsq_pkg::FSQ_ST_IGNORE;
                    end
                    fsq_pkg::FSQ_ST_DATA,
                    fsq_pkg::FSQ_ST_IGNORE: st_nxt = st_r;
                endcase
            end
        end else if (pins.sclk_fall && (st_r == fsq_pkg::FSQ_ST_DATA)) begin
            oe_nxt = oe_lanes;
            if (bcnt_r == 3'h0) begin
                out_nxt = f_put(byte_v, dlg);
                dat_nxt = 8'(byte_v << (3'h1 << dlg));
                bcnt_nxt = `FSQ_BYTE_LAST >> dlg;
                if (is_id) begin
                    idsel_nxt = ~idsel_r;
                end else begin
                    addr_nxt = addr_step;
                end
            end else begin
                out_nxt = f_put(dat_r, dlg);
                dat_nxt = 8'(dat_r << (3'h1 << dlg));
                bcnt_nxt = bcnt_r - 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            st_r       <= fsq_pkg::FSQ_ST_IGNORE;
            cmd_r      <= 8'h00;
            cont_cmd_r <= 8'h00;
            cnt_r      <= 5'h00;
            dum_r      <= 5'h00;
            sh_r       <= 24'h000000;
            addr_r     <= 24'h000000;
            cont_r     <= 1'b0;
            wdis_r     <= `FSQ_WRAP_DIS_RST;
            wlen_r     <= 2'h0;
            idsel_r    <= 1'b0;
            dat_r      <= 8'h00;
            bcnt_r     <= 3'h0;
            out_r      <= 4'h0;
            oe_r       <= 4'h0;
        end else begin
            st_r       <= st_nxt;
            cmd_r      <= cmd_nxt;
            cont_cmd_r <= cont_cmd_nxt;
            cnt_r      <= cnt_nxt;
            dum_r      <= dum_nxt;
            sh_r       <= sh_nxt;
            addr_r     <= addr_nxt;
            cont_r     <= cont_nxt;
            wdis_r     <= wdis_nxt;
            wlen_r     <= wlen_nxt;
            idsel_r    <= idsel_nxt;
            dat_r      <= dat_nxt;
            bcnt_r     <= bcnt_nxt;
            out_r      <= out_nxt;
            oe_r       <= oe_nxt;
        end
    end

    assign o_io           = out_r;
    assign o_io_oe        = oe_r;
    assign o_mem_addr     = addr_r;
    assign o_cont_mode    = cont_r;
    assign o_wrap_disable = wdis_r;
    assign o_wrap_len     = wlen_r;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    sequence s_byte_take;
        (st_r == fsq_pkg::FSQ_ST_DATA) && pins.sclk_fall && (bcnt_r == 3'h0)
            && !pins.cs_rise && !is_id;
    endsequence

    sequence s_enter_data;
        $rose(st_r == fsq_pkg::FSQ_ST_DATA);
    endsequence

    word_dummy_a: assert property (s_enter_data and (cmd_r == `FSQ_OP_WORD_RD)
        |-> dum_r == `FSQ_DUM_WORD) else $error("word read dummy count wrong");
    oct_nodummy_a: assert property (s_enter_data and (cmd_r == `FSQ_OP_OCT_RD)
        |-> dum_r == 5'h00) else $error("octal read took dummies");
    addr_inc_a: assert property (s_byte_take and !wrap_on
        |=> addr_r == $past(addr_r) + 24'h000001) else $error("address not advanced");
    wrap_fold_a: assert property (s_byte_take and wrap_on and (wlen_eff == 2'h0)
        |=> addr_r[23:3] == $past(addr_r[23:3])) else $error("wrap left section");
    qe_gate_a: assert property ((st_r == fsq_pkg::FSQ_ST_CMD) && pins.sclk_rise && last
        && !pins.cs_rise && !pins.cs_fall && (sh_in[7:0] == `FSQ_OP_WORD_RD) && !i_quad_enable
        |=> st_r == fsq_pkg::FSQ_ST_IGNORE) else $error("word read ran without enable");
    cont_skip_a: assert property (o_cont_mode && pins.cs_fall && !pins.cs_rise
        |=> (st_r == fsq_pkg::FSQ_ST_ADDR) && (cmd_r == $past(cont_cmd_r)))
        else $error("continuous mode did not skip opcode");
    cont_drop_a: assert property ((st_r == fsq_pkg::FSQ_ST_MODE) && pins.sclk_rise && last
        && !pins.cs_rise && !pins.cs_fall && (sh_in[`FSQ_MODE_FLD] != `FSQ_CONT_KEEP)
        |=> !o_cont_mode ##1 !o_cont_mode) else $error("continuous mode kept");
    reset_vals_a: assert property ($rose(i_nrst)
        |-> o_wrap_disable && !o_cont_mode && (o_io_oe == 4'h0))
        else $error("reset values wrong");
    wrap_set_a: assert property ((st_r == fsq_pkg::FSQ_ST_WARG) && pins.sclk_rise && last
        && !pins.cs_rise && !pins.cs_fall
        |=> (o_wrap_len == $past(sh_in[`FSQ_WRAP_LEN_FLD]))
        && (o_wrap_disable == $past(sh_in[`FSQ_WRAP_DIS_BIT])))
        else $error("wrap setting not stored");
    oe_frame_a: assert property (pins.cs_rise |=> (o_io_oe == 4'h0) [*2])
        else $error("io still driven after deselect");
endmodule
`default_nettype wire

// file: quad_read_wrap_and_id_reads_tb.sv
// Purpose: self-checking bench of the flash read sequencer
// Assumes: host model drives the pins, bench drives status and id levels
// Notes:   array content is a keyed function of the read address
`timescale 1ns/10ps
`default_nettype none
`include "fsq_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module quad_read_wrap_and_id_reads_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cs_n, sclk, quad_en, fwm;
    logic [3:0]  io_in, io_out, io_oe;
    logic [1:0]  dsel, wsel, wlen;
    logic [7:0]  mfr, dev, key, mem_data;
    logic [23:0] mem_addr, a;
    logic        cont, wdis;
    int          bad_count = 0;
    int          checks_done = 0;
    int          l, j, op, sec;
    always #5 clk = ~clk;
    function automatic logic [7:0] mem_fn(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ key;
    endfunction
    function automatic logic [23:0] exp_addr(input logic [23:0] b, input int i,
                                             input bit wr, input logic [1:0] len);
        logic [23:0] m;
        m = (24'h8 << len) - 24'h1;
        if (!wr) return b + 24'(i);
        return (b & ~m) | ((b + 24'(i)) & m);
    endfunction
    assign mem_data = mem_fn(mem_addr);
    fsq_host_model fsq_host_model_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_io(io_in),
                                        .i_io(io_out), .i_io_oe(io_oe));
    fsq_seq fsq_seq_inst (.i_clk_sys(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_io(io_in), .o_io(io_out), .o_io_oe(io_oe), .i_quad_enable(quad_en),
        .i_four_wire_mode(fwm), .i_param_dummy_sel(dsel), .i_param_wrap_sel(wsel),
        .i_mfr_id(mfr), .i_dev_id(dev), .i_mem_data(mem_data), .o_mem_addr(mem_addr),
        .o_cont_mode(cont), .o_wrap_disable(wdis), .o_wrap_len(wlen));
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // olanes 0 means a continuous frame without opcode
    task automatic quad_rd(input int olanes, input logic [7:0] opc, input logic [23:0] ad,
                           input logic [7:0] mode, input int dum, input int n);
        fsq_host_model_inst.frame_start();
        if (olanes > 0) fsq_host_model_inst.send(olanes, 32'(opc), 8, 1'b0);
        fsq_host_model_inst.send(4, 32'(ad), 24, 1'b0);
        if (opc != `FSQ_OP_WRAP_RD) fsq_host_model_inst.send(4, 32'(mode), 8, dum == 0);
        if (dum > 0) fsq_host_model_inst.send(4, 32'hFFFFFFFF, 4 * dum, 1'b1);
        fsq_host_model_inst.recv(4, n);
        fsq_host_model_inst.frame_end();
    endtask
    task automatic chk_rd(input logic [23:0] b, input int n, input bit wr, input logic [1:0] len);
        int i;
        for (i = 0; i < n; i++) begin
            `CHK(fsq_host_model_inst.rx[i], mem_fn(exp_addr(b, i, wr, len)))
        end
    endtask
    task automatic set_wrap(input logic [7:0] w);
        fsq_host_model_inst.frame_start();
        fsq_host_model_inst.send(1, 32'(`FSQ_OP_SET_WRAP), 8, 1'b0);
        fsq_host_model_inst.send(1, 32'h0, 24, 1'b0);
        fsq_host_model_inst.send(1, 32'(w), 8, 1'b0);
        fsq_host_model_inst.frame_end();
    endtask
    initial begin
        void'($urandom(32'hADEDAC41));
        quad_en = 1'b1;
        fwm = 1'b0;
        dsel = 2'($urandom);
        wsel = 2'($urandom);
        mfr = 8'($urandom);
        dev = 8'($urandom);
        key = 8'($urandom);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(wdis, 1'b1)
        `CHK(cont, 1'b0)
        // Id reads: single, dual, quad lanes, both start addresses
        for (op = 0; op < 6; op++) begin
            l = 1 << (op / 2);
            fsq_host_model_inst.frame_start();
            fsq_host_model_inst.send(1, 32'(8'h90 | 8'(op / 2) << 1), 8, 1'b0);
            fsq_host_model_inst.send(l, 32'(op % 2), 24, l != 4);
            if (l == 4) fsq_host_model_inst.send(4, 32'hFFFF, 16, 1'b1);
            fsq_host_model_inst.recv(l, 4);
            fsq_host_model_inst.frame_end();
            for (j = 0; j < 4; j++) begin
                `CHK(fsq_host_model_inst.rx[j], ((j ^ op) & 1) ? dev : mfr)
            end
        end
        // Every wrap length, word read and quad fast read alternately
        for (l = 0; l < 4; l++) begin
            set_wrap({1'($urandom), 2'(l), 1'b0, 4'($urandom)});
            `CHK(wdis, 1'b0)
            `CHK(wlen, 2'(l))
            sec = 8 << l;
            a = (24'($urandom) & ~24'(sec - 1)) | 24'(sec - 4);
            quad_rd(1, l[0] ? `FSQ_OP_QIO_RD : `FSQ_OP_WORD_RD, a, 8'h00, l[0] ? 4 : 2, 8);
            chk_rd(a, 8, 1'b1, 2'(l));
        end
        set_wrap(8'h10);
        `CHK(wdis, 1'b1)
        quad_rd(1, `FSQ_OP_WORD_RD, a, 8'h00, 2, 8);
        chk_rd(a, 8, 1'b0, 2'h0);
        // Quad reads refused without the quad enable bit
        @(posedge clk) quad_en <= 1'b0;
        quad_rd(1, `FSQ_OP_WORD_RD, a, 8'h00, 2, 2);
        `CHK(fsq_host_model_inst.oe_seen, 1'b0)
        quad_rd(1, `FSQ_OP_OCT_RD, a & 24'hFFFFF0, 8'h00, 0, 2);
        `CHK(fsq_host_model_inst.oe_seen, 1'b0)
        @(posedge clk) quad_en <= 1'b1;
        // Continuous octal word reads, then leave with all ones
        a = 24'($urandom) & 24'hFFFFF0;
        quad_rd(1, `FSQ_OP_OCT_RD, a, {2'($urandom), 2'h2, 4'($urandom)}, 0, 4);
        chk_rd(a, 4, 1'b0, 2'h0);
        `CHK(cont, 1'b1)
        a = 24'($urandom) & 24'hFFFFF0;
        quad_rd(0, `FSQ_OP_OCT_RD, a, 8'h2F, 0, 4);
        chk_rd(a, 4, 1'b0, 2'h0);
        fsq_host_model_inst.frame_start();
        fsq_host_model_inst.send(4, 32'hFFFFFFFF, 32, 1'b0);
        fsq_host_model_inst.frame_end();
        `CHK(cont, 1'b0)
        quad_rd(1, `FSQ_OP_WORD_RD, a, 8'h00, 2, 2);
        chk_rd(a, 2, 1'b0, 2'h0);
        // Burst wrap read in four-wire command mode
        @(posedge clk) fwm <= 1'b1;
        sec = 8 << wsel;
        a = (24'($urandom) & ~24'(sec - 1)) | 24'(sec - 3);
        quad_rd(4, `FSQ_OP_WRAP_RD, a, 8'h00, 2 * (dsel + 1), 10);
        chk_rd(a, 10, 1'b1, wsel);
        end_of_test();
    end
    initial begin
        #900us;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
